// file: src/dtm_defs.vh
// constants for the dual timer mode configuration block
`ifndef DTM_DEFS_VH
`define DTM_DEFS_VH

// ---------------------------------------------------------------
// register addresses (special-function space)
// ---------------------------------------------------------------
`define DTM_ADDR_CONTROL   8'h88
`define DTM_ADDR_MODE      8'h89
`define DTM_ADDR_A_LOW     8'h8a
`define DTM_ADDR_B_LOW     8'h8b
`define DTM_ADDR_A_HIGH    8'h8c
`define DTM_ADDR_B_HIGH    8'h8d

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DTM_RST_CONTROL    8'h00
`define DTM_RST_MODE       8'h00
`define DTM_RST_COUNT      8'h00

// ---------------------------------------------------------------
// timer_mode field positions
// ---------------------------------------------------------------
`define DTM_B_GATE_BIT     7
`define DTM_B_SRC_BIT      6
`define DTM_B_MODE_HI      5
`define DTM_B_MODE_LO      4
`define DTM_A_GATE_BIT     3
`define DTM_A_SRC_BIT      2
`define DTM_A_MODE_HI      1
`define DTM_A_MODE_LO      0

// ---------------------------------------------------------------
// timer_control field positions
// ---------------------------------------------------------------
`define DTM_B_OVF_BIT      7
`define DTM_B_RUN_BIT      6
`define DTM_A_OVF_BIT      5
`define DTM_A_RUN_BIT      4

// ---------------------------------------------------------------
// mode encodings
// ---------------------------------------------------------------
`define DTM_MODE_PRESCALE  2'b00
`define DTM_MODE_CASCADE   2'b01
`define DTM_MODE_RELOAD    2'b10
`define DTM_MODE_SPLIT     2'b11

// ---------------------------------------------------------------
// timing: core clocks per machine cycle, prescaler top
// ---------------------------------------------------------------
`define DTM_CLKS_PER_MC    12
`define DTM_MC_CNT_TOP     4'd11
`define DTM_PRESCALE_TOP   5'h1f

`endif

// file: src/dtm_unit.v
// one 16-bit timer/counter with mode-dependent byte structure
`timescale 1ns/1ps
`default_nettype none
`include "dtm_defs.vh"

module dtm_unit (
   // clock and reset
   input  wire       clk_in,
   input  wire       rst_in,
   // count control
   input  wire       low_tick_in,
   input  wire       high_tick_in,
   input  wire [1:0] mode_in,
   // software writes
   input  wire       low_wr_in,
   input  wire       high_wr_in,
   input  wire [7:0] wdata_in,
   // state
   output reg  [7:0] low_q,
   output reg  [7:0] high_q,
   output reg        low_ovf_out,
   output reg        high_ovf_out
);

   // ---------------------------------------------------------------
   // counting datapath
   // ---------------------------------------------------------------
   reg  [7:0] low_d;
   reg  [7:0] high_d;
   reg        low_ovf_d;
   reg        high_ovf_d;

   // next count; software writes win over a same-cycle increment
   always @* begin
      low_d      = low_q;
      high_d     = high_q;
      low_ovf_d  = 1'b0;
      high_ovf_d = 1'b0;
      case (mode_in)
         `DTM_MODE_PRESCALE: begin
            if (low_tick_in) begin
               low_d = {3'b000, low_q[4:0] + 5'h01};
               if (low_q[4:0] == `DTM_PRESCALE_TOP) begin
                  high_d = high_q + 8'h01;
                  if (high_q == 8'hff) begin
                     high_ovf_d = 1'b1;
                  end
               end
            end
         end
         `DTM_MODE_CASCADE: begin
            if (low_tick_in) begin
               low_d = low_q + 8'h01;
               if (low_q == 8'hff) begin
                  high_d = high_q + 8'h01;
                  if (high_q == 8'hff) begin
                     high_ovf_d = 1'b1;
                  end
               end
            end
         end
         `DTM_MODE_RELOAD: begin
            if (low_tick_in) begin
               if (low_q == 8'hff) begin
                  low_d     = high_q;
                  low_ovf_d = 1'b1;
               end else begin
                  low_d = low_q + 8'h01;
               end
            end
         end
         default: begin
            // split: two separate 8-bit counters; unit B never ticks here
            if (low_tick_in) begin
               low_d = low_q + 8'h01;
               if (low_q == 8'hff) begin
                  low_ovf_d = 1'b1;
               end
            end
            if (high_tick_in) begin
               high_d = high_q + 8'h01;
               if (high_q == 8'hff) begin
                  high_ovf_d = 1'b1;
               end
            end
         end
      endcase
      if (low_wr_in) begin
         low_d = wdata_in;
      end
      if (high_wr_in) begin
         high_d = wdata_in;
      end
   end

   // count registers; mode changes never touch the counts
   always @(posedge clk_in) begin
      if (rst_in) begin
         low_q        <= `DTM_RST_COUNT;
         high_q       <= `DTM_RST_COUNT;
         low_ovf_out  <= 1'b0;
         high_ovf_out <= 1'b0;
      end else begin
         low_q        <= low_d;
         high_q       <= high_d;
         low_ovf_out  <= low_ovf_d;
         high_ovf_out <= high_ovf_d;
      end
   end

endmodule
`default_nettype wire

// file: src/dtm_top.v
// dual timer/counter mode configuration and counting block
`timescale 1ns/1ps
`default_nettype none
`include "dtm_defs.vh"

// Functional notes
// - unit B gate set: count only while gate pin high and run set
// - unit B gate clear: count whenever run bit is set
// - unit B source bit: one counts pin events, zero machine cycles
// - unit B mode 00: high byte counts through 5-bit low prescaler
// - unit B mode 01: low and high bytes form one 16-bit counter
// - unit B mode 10: low byte counts, reloads from high on overflow
// - unit A gate set: count only while gate pin high and run set
// - unit A gate clear: count whenever run bit is set
// - unit A source bit: one counts pin events, zero machine cycles
// - unit A mode 00: high byte counts through 5-bit low prescaler
// - unit A mode 01: low and high bytes form one 16-bit counter
// - unit A mode 10: low byte counts, reloads from high on overflow
// - unit A mode 11: low byte is own 8-bit counter, own controls
// - unit A mode 11: high byte is timer using B run and B flag
// - timer mode counts once per machine cycle of twelve clocks
// - counter mode counts pin falls, sampled once per machine cycle
// - rollover to zero sets the unit's overflow flag
// - unit B mode 11 holds its count as if run were clear
module dtm_top (
   // clock and reset
   input  wire       clk_in,
   input  wire       rst_in,
   // register port
   input  wire [7:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   input  wire       reg_wr_in,
   input  wire       reg_rd_in,
   output reg  [7:0] reg_rdata_out,
   // external pins
   input  wire       unit_a_gate_pin_in,
   input  wire       unit_b_gate_pin_in,
   input  wire       unit_a_count_pin_in,
   input  wire       unit_b_count_pin_in,
   // status
   output reg        unit_a_overflow_flag_out,
   output reg        unit_b_overflow_flag_out
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   reg  [3:0] pin_meta_q;
   reg  [3:0] pin_sync_q;
   wire [3:0] pin_raw = {unit_b_count_pin_in, unit_a_count_pin_in,
                         unit_b_gate_pin_in, unit_a_gate_pin_in};

   // two stages per pin; only the second stage is read
   always @(posedge clk_in) begin
      if (rst_in) begin
         pin_meta_q <= 4'h0;
         pin_sync_q <= 4'h0;
      end else begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
      end
   end

   wire a_gate_pin  = pin_sync_q[0];
   wire b_gate_pin  = pin_sync_q[1];
   wire a_count_pin = pin_sync_q[2];
   wire b_count_pin = pin_sync_q[3];

   // ---------------------------------------------------------------
   // machine cycle strobe
   // ---------------------------------------------------------------
   reg  [3:0] mc_cnt_q;
   wire       mc_tick = (mc_cnt_q == `DTM_MC_CNT_TOP);

   // one strobe every twelve core clocks
   always @(posedge clk_in) begin
      if (rst_in) begin
         mc_cnt_q <= 4'h0;
      end else if (mc_tick) begin
         mc_cnt_q <= 4'h0;
      end else begin
         mc_cnt_q <= mc_cnt_q + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // pin fall detection, sampled once per machine cycle
   // ---------------------------------------------------------------
   reg  [1:0] cnt_smp_q;
   wire       a_fall = mc_tick & cnt_smp_q[0] & ~a_count_pin;
   wire       b_fall = mc_tick & cnt_smp_q[1] & ~b_count_pin;

   // previous machine cycle sample of each count pin
   always @(posedge clk_in) begin
      if (rst_in) begin
         cnt_smp_q <= 2'b00;
      end else if (mc_tick) begin
         cnt_smp_q <= {b_count_pin, a_count_pin};
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg  [7:0] mode_q;
   reg  [7:0] ctrl_q;
   reg  [7:0] mode_act_q;

   wire [7:0] a_low;
   wire [7:0] a_high;
   wire [7:0] b_low;
   wire [7:0] b_high;
   wire       a_low_ovf;
   wire       a_high_ovf;
   wire       b_low_ovf;
   wire       b_high_ovf;

   wire wr_ctrl   = reg_wr_in & (reg_addr_in == `DTM_ADDR_CONTROL);
   wire wr_mode   = reg_wr_in & (reg_addr_in == `DTM_ADDR_MODE);

   // mode field decode uses the copy taken at machine cycle edges
   wire [1:0] a_mode = mode_act_q[`DTM_A_MODE_HI:`DTM_A_MODE_LO];
   wire [1:0] b_mode = mode_act_q[`DTM_B_MODE_HI:`DTM_B_MODE_LO];
   wire       a_split = (a_mode == `DTM_MODE_SPLIT);

   // overflow events; in split mode the high byte of A also sets B's flag, as do B's own overflows
   wire a_ovf_evt = (a_mode == `DTM_MODE_RELOAD || a_split) ? a_low_ovf : a_high_ovf;
   wire b_ovf_evt = a_split ? (a_high_ovf | b_high_ovf | b_low_ovf)
                            : (b_mode == `DTM_MODE_RELOAD ? b_low_ovf : b_high_ovf);

   // mode and control registers; hardware flag set wins over a clear
   always @(posedge clk_in) begin
      if (rst_in) begin
         mode_q     <= `DTM_RST_MODE;
         mode_act_q <= `DTM_RST_MODE;
         ctrl_q     <= `DTM_RST_CONTROL;
      end else begin
         if (wr_mode) begin
            mode_q <= reg_wdata_in;
         end
         if (mc_tick) begin
            mode_act_q <= mode_q;
         end
         if (wr_ctrl) begin
            ctrl_q <= reg_wdata_in;
         end
         if (a_ovf_evt) begin
            ctrl_q[`DTM_A_OVF_BIT] <= 1'b1;
         end
         if (b_ovf_evt) begin
            ctrl_q[`DTM_B_OVF_BIT] <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // count enables
   // ---------------------------------------------------------------
   wire a_run = ctrl_q[`DTM_A_RUN_BIT];
   wire b_run = ctrl_q[`DTM_B_RUN_BIT];
   // gated count needs the gate pin high when the gate bit is set
   wire a_en  = a_run & (~mode_act_q[`DTM_A_GATE_BIT] | a_gate_pin);
   wire b_en  = b_run & (~mode_act_q[`DTM_B_GATE_BIT] | b_gate_pin);
   // source select: pin falls or machine cycles
   wire a_evt = mode_act_q[`DTM_A_SRC_BIT] ? a_fall : mc_tick;
   wire b_evt = mode_act_q[`DTM_B_SRC_BIT] ? b_fall : mc_tick;
   wire a_low_tick  = a_en & a_evt;
   wire a_high_tick = a_split & b_run & mc_tick;
   // unit B frozen in its own mode 11
   wire b_low_tick  = b_en & b_evt & (b_mode != `DTM_MODE_SPLIT);

   // ---------------------------------------------------------------
   // counter units
   // ---------------------------------------------------------------
   dtm_unit u_unit_a (
      .clk_in       (clk_in),
      .rst_in       (rst_in),
      .low_tick_in  (a_low_tick),
      .high_tick_in (a_high_tick),
      .mode_in      (a_mode),
      .low_wr_in    (reg_wr_in & (reg_addr_in == `DTM_ADDR_A_LOW)),
      .high_wr_in   (reg_wr_in & (reg_addr_in == `DTM_ADDR_A_HIGH)),
      .wdata_in     (reg_wdata_in),
      .low_q        (a_low),
      .high_q       (a_high),
      .low_ovf_out  (a_low_ovf),
      .high_ovf_out (a_high_ovf)
   );

   // unit B mode 11 is mapped to hold in the parent, never split here
   dtm_unit u_unit_b (
      .clk_in       (clk_in),
      .rst_in       (rst_in),
      .low_tick_in  (b_low_tick),
      .high_tick_in (1'b0),
      .mode_in      (b_mode),
      .low_wr_in    (reg_wr_in & (reg_addr_in == `DTM_ADDR_B_LOW)),
      .high_wr_in   (reg_wr_in & (reg_addr_in == `DTM_ADDR_B_HIGH)),
      .wdata_in     (reg_wdata_in),
      .low_q        (b_low),
      .high_q       (b_high),
      .low_ovf_out  (b_low_ovf),
      .high_ovf_out (b_high_ovf)
   );

   // ---------------------------------------------------------------
   // read data and flag outputs
   // ---------------------------------------------------------------
   reg [7:0] rdata_d;

   // unmapped addresses read as zero
   always @* begin
      case (reg_addr_in)
         `DTM_ADDR_CONTROL: rdata_d = ctrl_q;
         `DTM_ADDR_MODE:    rdata_d = mode_q;
         `DTM_ADDR_A_LOW:   rdata_d = a_low;
         `DTM_ADDR_B_LOW:   rdata_d = b_low;
         `DTM_ADDR_A_HIGH:  rdata_d = a_high;
         `DTM_ADDR_B_HIGH:  rdata_d = b_high;
         default:           rdata_d = 8'h00;
      endcase
   end

   // registered read data, one cycle after the read strobe
   always @(posedge clk_in) begin
      if (rst_in) begin
         reg_rdata_out            <= 8'h00;
         unit_a_overflow_flag_out <= 1'b0;
         unit_b_overflow_flag_out <= 1'b0;
      end else begin
         if (reg_rd_in) begin
            reg_rdata_out <= rdata_d;
         end
         unit_a_overflow_flag_out <= ctrl_q[`DTM_A_OVF_BIT];
         unit_b_overflow_flag_out <= ctrl_q[`DTM_B_OVF_BIT];
      end
   end

endmodule
`default_nettype wire

// file: test/dtm_top_assertions.sv
// checker for the register port and overflow flags of the dual timer
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module dtm_checker (
   // clock and reset
   input wire logic       clk_in,
   input wire logic       rst_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   // flags
   input wire logic       unit_a_overflow_flag_out,
   input wire logic       unit_b_overflow_flag_out
);
   logic [3:0] phase_q;
   logic [3:0] phase_d;
   wire        fa      = unit_a_overflow_flag_out;
   wire        fb      = unit_b_overflow_flag_out;
   wire  [7:0] rdat    = reg_rdata_out;
   wire        ctrl_wr = reg_wr_in && (reg_addr_in == 8'h88);
   default clocking dck @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // machine-cycle phase, restarted by reset like the design's divider
   assign phase_d = (phase_q == 4'd11) ? 4'd0 : phase_q + 4'd1;
   always_ff @(posedge clk_in) begin
      if (rst_in) phase_q <= 4'd0;
      else phase_q <= phase_d;
   end
   reset_clear_a: assert property (
      $fell(rst_in) |-> !fa && !fb) else $error("flags set after reset");
   ctrl_flags_a: assert property (
      reg_rd_in && reg_addr_in == 8'h88 |=> rdat[7] == fb && rdat[5] == fa)
      else $error("flag outputs differ from control read");
   unmapped_zero_a: assert property (
      reg_rd_in && (reg_addr_in < 8'h88 || reg_addr_in > 8'h8d) |=> rdat == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (
      !reg_rd_in |=> $stable(rdat)) else $error("read data moved without a read");
   mode_readback_a: assert property (
      reg_wr_in && reg_addr_in == 8'h89 ##1 !reg_wr_in ##1 reg_rd_in && reg_addr_in == 8'h89
      |=> rdat == $past(reg_wdata_in, 3)) else $error("mode readback wrong");
   a_flag_clear_a: assert property (
      $fell(fa) |-> $past(ctrl_wr, 2)) else $error("unit a flag fell without a write");
   b_flag_clear_a: assert property (
      $fell(fb) |-> $past(ctrl_wr, 2)) else $error("unit b flag fell without a write");
   a_flag_phase_a: assert property (
      $rose(fa) |-> phase_q inside {[4'd2:4'd4]} || $past(ctrl_wr, 2))
      else $error("unit a flag rose off the machine cycle");
   b_flag_phase_a: assert property (
      $rose(fb) |-> phase_q inside {[4'd2:4'd4]} || $past(ctrl_wr, 2))
      else $error("unit b flag rose off the machine cycle");
endmodule
bind dtm_top dtm_checker dtm_checker_i (
   .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .unit_a_overflow_flag_out(unit_a_overflow_flag_out),
   .unit_b_overflow_flag_out(unit_b_overflow_flag_out));
`default_nettype wire

// file: test/dtm_pin_model.sv
// model of the gate and count pins of both timer units
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// pin driver
// ----------------------------------------
module dtm_pin_model (
   // clock
   input  wire logic clk_in,
   // pins
   output wire logic unit_a_gate_pin_out,
   output wire logic unit_b_gate_pin_out,
   output wire logic unit_a_count_pin_out,
   output wire logic unit_b_count_pin_out
);
   logic [1:0] gate_q = 2'b00;
   logic [1:0] cnt_q  = 2'b11;
   // count pins idle high so the first low is a real fall
   assign unit_a_gate_pin_out  = gate_q[0];
   assign unit_b_gate_pin_out  = gate_q[1];
   assign unit_a_count_pin_out = cnt_q[0];
   assign unit_b_count_pin_out = cnt_q[1];
   // gate high for exactly n edges, so n/12 machine cycles are let through
   task automatic gate_pulse(input int u, input int n);
      @(posedge clk_in);
      gate_q[u] <= 1'b1;
      repeat (n) @(posedge clk_in);
      gate_q[u] <= 1'b0;
   endtask
   // each level held two machine cycles so every sample sees it
   task automatic falls(input int u, input int n);
      repeat (n) begin
         cnt_q[u] <= 1'b0;
         repeat (24) @(posedge clk_in);
         cnt_q[u] <= 1'b1;
         repeat (24) @(posedge clk_in);
      end
   endtask
endmodule
`default_nettype wire

// file: test/dtm_top_tb_top.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench top
// ----------------------------------------
module dtm_top_tb_top;
   logic        clk_in;
   logic        rst_in       = 1'b1;
   logic [7:0]  reg_addr_in  = 8'h00;
   logic [7:0]  reg_wdata_in = 8'h00;
   logic        reg_wr_in    = 1'b0;
   logic        reg_rd_in    = 1'b0;
   logic        rd_seen      = 1'b0;
   logic [7:0]  reg_rdata_out;
   logic        ga, gb, ca, cb, fa, fb;
   logic [7:0]  exp_q[$];
   logic [31:0] rnd = 32'h6330af36;
   logic [15:0] v;
   int          fails = 0;
   int          tests_run = 0;
   int          k;

   dtm_top dtm_top_i (
      .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .unit_a_gate_pin_in(ga), .unit_b_gate_pin_in(gb),
      .unit_a_count_pin_in(ca), .unit_b_count_pin_in(cb),
      .unit_a_overflow_flag_out(fa), .unit_b_overflow_flag_out(fb));
   dtm_pin_model dtm_pin_model_i (
      .clk_in(clk_in), .unit_a_gate_pin_out(ga), .unit_b_gate_pin_out(gb),
      .unit_a_count_pin_out(ca), .unit_b_count_pin_out(cb));

   // 250 MHz core clock
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // write held one edge, taken at the second
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   // read request; the expected byte waits in the queue for the monitor
   task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
   endtask
   task automatic check(input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   // flag outputs are levels, so they are compared away from the clock edge
   task automatic check_flag(input logic [1:0] e, input logic [1:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: flags expected %h got %h", $time, e, g);
      end
   endtask
   // read data lands one edge after the read is taken
   always @(posedge clk_in) rd_seen <= reg_rd_in;
   always @(negedge clk_in) begin
      if (rd_seen) check(exp_q.pop_front(), reg_rdata_out);
   end
   // one counting run of unit u; mf holds the unit's four mode bits
   task automatic trial(input int u, input logic [3:0] mf, input logic [7:0] lo, hi,
                        input int n, input logic [7:0] elo, ehi, ectl);
      logic [7:0] run;
      run = 8'h10 << (2 * u);
      reg_write(8'h88, 8'h00);
      reg_write(8'h89, 8'(mf) << (4 * u));
      repeat (12) @(posedge clk_in);
      reg_write(8'(8'h8a + u), lo);
      reg_write(8'(8'h8c + u), hi);
      reg_write(8'h88, run);
      if (mf[3] && n > 0) dtm_pin_model_i.gate_pulse(u, 12 * n);
      else if (mf[3]) repeat (36) @(posedge clk_in);
      else begin
         if (mf[2]) begin
            dtm_pin_model_i.falls(u, n);
            repeat (36) @(posedge clk_in);
         end else repeat (12 * n - 2) @(posedge clk_in);
         reg_write(8'h88, 8'h00);
      end
      repeat (8) @(posedge clk_in);
      reg_read(8'(8'h8a + u), elo);
      reg_read(8'(8'h8c + u), ehi);
      reg_read(8'h88, ectl);
      @(negedge clk_in);
      check_flag({ectl[7], ectl[5]}, {fb, fa});
      $display("trial unit %0d mode bits %h done", u, mf);
   endtask
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // the run needs some 1.7 k cycles; a hang is cut well beyond that
   initial begin
      #100000;
      fails++;
      summarize();
   end
   // main sequence
   initial begin
      logic [7:0] r, f;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int a = 8'h88; a <= 8'h8d; a++) reg_read(8'(a), 8'h00);
      reg_write(8'h90, 8'h5a);
      reg_read(8'h90, 8'h00);
      reg_write(8'h89, 8'ha5);
      reg_read(8'h89, 8'ha5);
      $display("reset values and access done");
      for (int u = 0; u < 2; u++) begin
         r = 8'h10 << (2 * u);
         f = 8'h20 << (2 * u);
         repeat (2) begin
            rnd = xs(rnd);
            k = 1 + int'(rnd[9:8]);
            v = {8'hff, rnd[7:0]} + 16'(k);
            trial(u, 4'h9, rnd[7:0], 8'hff, k, v[7:0], v[15:8], (v < 16'(k)) ? r | f : r);
         end
         trial(u, 4'h8, 8'h1e, 8'hff, 3, 8'h01, 8'h00, r | f);
         trial(u, 4'ha, 8'hfe, 8'h80, 4, 8'h82, 8'h80, r | f);
         trial(u, 4'h9, 8'h33, 8'h44, 0, 8'h33, 8'h44, r);
         trial(u, 4'h1, 8'h70, 8'h01, 5, 8'h75, 8'h01, 8'h00);
         trial(u, 4'h5, 8'hfe, 8'h12, 3, 8'h01, 8'h13, 8'h00);
      end
      trial(1, 4'h3, 8'h40, 8'h50, 2, 8'h40, 8'h50, 8'h00);
      trial(0, 4'h3, 8'h10, 8'h20, 2, 8'h12, 8'h20, 8'h00);
      reg_write(8'h88, 8'h40);
      repeat (34) @(posedge clk_in);
      reg_write(8'h88, 8'h00);
      reg_read(8'h8c, 8'h23);
      reg_read(8'h8a, 8'h12);
      reg_write(8'h89, 8'h01);
      repeat (14) @(posedge clk_in);
      reg_read(8'h8a, 8'h12);
      reg_read(8'h8c, 8'h23);
      // back to split: the high byte of A wraps on B's run and raises B's flag
      reg_write(8'h89, 8'h03);
      reg_write(8'h8c, 8'hff);
      reg_write(8'h88, 8'h40);
      repeat (24) @(posedge clk_in);
      reg_read(8'h88, 8'hc0);
      @(negedge clk_in);
      check_flag(2'b10, {fb, fa});
      $display("split mode and mode change done");
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      reg_read(8'h89, 8'h00);
      reg_read(8'h8c, 8'h00);
      $display("second reset done");
      repeat (4) @(posedge clk_in);
      summarize();
   end
endmodule
`default_nettype wire
